/* File: verilog/adaptive_threshold_map.vh */
// Behaviour
// RULE1: time constant is two to settling-code-plus-one
// RULE2: average at step zero is prior average
// RULE3: average updates once per finished conversion
// RULE4: 8-bit config register at pointer 0x0F
// RULE5: config resets to 0x19
// RULE6: fixed select one compares against threshold
// RULE7: fixed select zero compares against adaptive threshold
// RULE8: mode 00 active below lower limit
// RULE9: mode 01 active above upper limit
// RULE10: mode 10 inside band, 11 outside
// RULE11: average follows first-order exponential filter
// RULE12: hysteresis only in adaptive, unless disabled
// RULE13: mode field idle/continuous/single/power-down, 1xx reserved
// RULE14: channel enables; continuous alternates both channels
`ifndef ADAPTIVE_THRESHOLD_MAP_VH
`define ADAPTIVE_THRESHOLD_MAP_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CFG_POINTER      8'h0f
`define CFG_RESET        8'h19
`define CFG_FIXED_BIT    7
`define CFG_CMP_HI_BIT   6
`define CFG_CMP_LO_BIT   5
`define CFG_EN1_BIT      4
`define CFG_EN2_BIT      3
`define CFG_MODE_MSB     2
`define CFG_MODE_LSB     0

// ----------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------
`define MODE_IDLE        3'h0
`define MODE_CONTINUOUS  3'h1
`define MODE_SINGLE      3'h2
`define MODE_POWERDOWN   3'h3
`define CMP_NEGATIVE     2'h0
`define CMP_POSITIVE     2'h1
`define CMP_IN_WINDOW    2'h2
`define CMP_OUT_WINDOW   2'h3
`define UNMAPPED_READ    8'h00

`endif

/* File: verilog/adaptive_threshold_comparator.v */
`timescale 1ns/1ps
`include "adaptive_threshold_map.vh"

module adaptive_threshold_comparator #(
   parameter DATA_W = 16,
   parameter FRAC_W = 16
) (
   input  wire              clk_sys,
   input  wire              resetn,
   input  wire [7:0]        regPointer,
   input  wire              regWrite,
   input  wire [7:0]        regWriteData,
   output wire [7:0]        regReadData,
   input  wire [3:0]        average_settling_code,
   input  wire              hysteresisDisable,
   input  wire [DATA_W-1:0] hysteresisAmount,
   input  wire [DATA_W-1:0] sensitivity0,
   input  wire [DATA_W-1:0] sensitivity1,
   input  wire [DATA_W-1:0] fixedThreshold0,
   input  wire [DATA_W-1:0] fixedThreshold1,
   output reg               convStart,
   output reg               convChannel,
   input  wire              convDone,
   input  wire [DATA_W-1:0] convData,
   output wire              powerDown,
   output reg  [1:0]        detect,
   output reg  [DATA_W-1:0] average0,
   output reg  [DATA_W-1:0] average1
);

   localparam       ACC_W   = DATA_W + FRAC_W;
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_BUSY = 2'h2;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // avg += (data - avg) / 2^(code+1), kept with fraction bits so
   // long time constants still move the average
   function [ACC_W-1:0] filterStep;
      input        [ACC_W-1:0]  acc;
      input        [DATA_W-1:0] data;
      input        [3:0]        code;
      reg   signed [ACC_W:0]    diff;
      reg   signed [ACC_W:0]    step;
      begin
         diff = $signed({1'h0, data, {FRAC_W{1'h0}}})
              - $signed({1'h0, acc});
         step = diff >>> ({1'h0, code} + 5'h1); // RULE1
         filterStep = acc + step[ACC_W-1:0]; // RULE11
      end
   endfunction

   // integer part of an accumulator
   function [DATA_W-1:0] intPart;
      input [ACC_W-1:0] acc;
      begin
         intPart = acc[ACC_W-1:FRAC_W];
      end
   endfunction

   // a - b, held at zero instead of wrapping
   function [DATA_W-1:0] subFloor;
      input [DATA_W-1:0] a;
      input [DATA_W-1:0] b;
      reg   [DATA_W:0]   diff;
      begin
         diff = {1'h0, a} - {1'h0, b};
         if (diff[DATA_W])
            subFloor = {DATA_W{1'h0}};
         else
            subFloor = diff[DATA_W-1:0];
      end
   endfunction

   // lo/hi are the band around average or threshold; a lower limit
   // clamped at zero leaves negative mode inactive
   function compareOut;
      input [DATA_W-1:0] data;
      input [DATA_W-1:0] centre;
      input [DATA_W-1:0] margin;
      input [1:0]        mode;
      reg   [DATA_W:0]   lo;
      reg   [DATA_W:0]   hi;
      reg   [DATA_W:0]   d;
      begin
         d  = {1'h0, data};
         lo = {1'h0, subFloor(centre, margin)};
         hi = {1'h0, centre} + {1'h0, margin};
         case (mode)
            `CMP_NEGATIVE:   compareOut = (d < lo); // RULE8
            `CMP_POSITIVE:   compareOut = (d > hi); // RULE9
            `CMP_IN_WINDOW:  compareOut = (d > lo) && (d < hi); // RULE10
            `CMP_OUT_WINDOW: compareOut = (d < lo) || (d > hi); // RULE10
            default:         compareOut = 1'h0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   reg  [7:0] cfgByte;
   reg  [7:0] next_cfgByte;
   reg        singleDoneEvent;
   wire       cfgHit;
   wire       fixedSel;
   wire [1:0] cmpMode;
   wire [1:0] chanEn;
   wire [2:0] convMode;

   assign cfgHit   = (regPointer == `CFG_POINTER);
   assign fixedSel = cfgByte[`CFG_FIXED_BIT];
   assign cmpMode  = {cfgByte[`CFG_CMP_HI_BIT], cfgByte[`CFG_CMP_LO_BIT]};
   assign chanEn   = {cfgByte[`CFG_EN2_BIT], cfgByte[`CFG_EN1_BIT]};
   assign convMode = cfgByte[`CFG_MODE_MSB:`CFG_MODE_LSB];

   assign regReadData = cfgHit ? cfgByte : `UNMAPPED_READ; // RULE4
   assign powerDown   = (convMode == `MODE_POWERDOWN); // RULE13

   // a software write wins over the single-shot return to idle
   always @* begin
      next_cfgByte = cfgByte;
      if (regWrite && cfgHit) begin
         next_cfgByte = regWriteData; // RULE4
      end else if (singleDoneEvent) begin
         next_cfgByte[`CFG_MODE_MSB:`CFG_MODE_LSB] = `MODE_IDLE; // RULE13
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfgByte <= `CFG_RESET; // RULE5
      end else begin
         cfgByte <= next_cfgByte;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   reg  [1:0] state;
   reg  [1:0] next_state;
   reg        lastChannel;
   reg        singleArmed;
   reg        next_singleArmed;
   reg        singleSecond;
   reg        next_singleSecond;
   reg        next_singleDone;
   reg        prevSingle;
   wire       singleSel;
   wire       runMode;
   wire       anyChan;
   wire       startNow;
   wire       pickChannel;

   assign singleSel = (convMode == `MODE_SINGLE);
   // power-down and the reserved codes never start a conversion
   assign runMode   = (convMode == `MODE_CONTINUOUS) ||
                      (singleSel && singleArmed); // RULE13
   assign anyChan   = (chanEn != 2'h0);
   assign startNow  = (state == ST_IDLE) && (next_state == ST_BUSY);
   // alternate when both channels run, else the one enabled
   assign pickChannel = (chanEn == 2'h3) ? ~lastChannel :
                        chanEn[1]; // RULE14

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (runMode && anyChan)
               next_state = ST_BUSY; // RULE13
         end
         ST_BUSY: begin
            if (convDone)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // single mode: one conversion per enabled channel, then idle
   always @* begin
      next_singleArmed  = singleArmed;
      next_singleSecond = singleSecond;
      next_singleDone   = 1'h0;
      if (singleSel && !prevSingle) begin
         next_singleArmed  = 1'h1;
         next_singleSecond = (chanEn == 2'h3);
      end else if (state == ST_BUSY && convDone && singleSel) begin
         if (singleSecond) begin
            next_singleSecond = 1'h0;
         end else begin
            next_singleArmed = 1'h0;
            next_singleDone  = 1'h1; // RULE13
         end
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state           <= ST_IDLE;
         convStart       <= 1'h0;
         convChannel     <= 1'h0;
         lastChannel     <= 1'h1;
         singleArmed     <= 1'h0;
         singleSecond    <= 1'h0;
         singleDoneEvent <= 1'h0;
         prevSingle      <= 1'h0;
      end else begin
         state           <= next_state;
         convStart       <= startNow;
         singleArmed     <= next_singleArmed;
         singleSecond    <= next_singleSecond;
         singleDoneEvent <= next_singleDone;
         prevSingle      <= singleSel;
         if (startNow) begin
            convChannel <= pickChannel; // RULE14
            lastChannel <= pickChannel;
         end
      end
   end

   // ----------------------------------------------------------------
   // average and detection
   // ----------------------------------------------------------------
   reg  [ACC_W-1:0]  acc0;
   reg  [ACC_W-1:0]  acc1;
   reg  [ACC_W-1:0]  next_acc0;
   reg  [ACC_W-1:0]  next_acc1;
   reg  [1:0]        next_detect;
   wire              ch;
   wire [ACC_W-1:0]  accCur;
   wire [DATA_W-1:0] avgCur;
   wire [DATA_W-1:0] sensCur;
   wire [DATA_W-1:0] thrCur;
   wire              hystOn;
   wire [DATA_W-1:0] marginAdapt;
   wire              hitAdapt;
   wire              hitFixed;
   wire              hit;
   wire              takeResult;

   assign ch      = convChannel;
   assign accCur  = ch ? acc1 : acc0;
   assign avgCur  = intPart(accCur);
   assign sensCur = ch ? sensitivity1 : sensitivity0;
   assign thrCur  = ch ? fixedThreshold1 : fixedThreshold0;
   // hysteresis narrows the release margin of an active output;
   // never in fixed mode, where it would shift the threshold
   assign hystOn  = !fixedSel && !hysteresisDisable && detect[ch]; // RULE12
   assign marginAdapt = hystOn ? subFloor(sensCur, hysteresisAmount) :
                        sensCur;
   // detection uses the average held before this result
   assign hitAdapt = compareOut(convData, avgCur, marginAdapt,
                                cmpMode); // RULE7 RULE2
   // fixed mode has no window limits: a zero-width band
   assign hitFixed = compareOut(convData, thrCur, {DATA_W{1'h0}},
                                cmpMode); // RULE6
   assign hit        = fixedSel ? hitFixed : hitAdapt;
   assign takeResult = (state == ST_BUSY) && convDone;

   always @* begin
      next_acc0   = acc0;
      next_acc1   = acc1;
      next_detect = detect;
      if (takeResult) begin
         if (ch) begin
            next_acc1      = filterStep(acc1, convData,
                                        average_settling_code); // RULE3
            next_detect[1] = hit;
         end else begin
            next_acc0      = filterStep(acc0, convData,
                                        average_settling_code); // RULE3
            next_detect[0] = hit;
         end
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc0     <= {ACC_W{1'h0}};
         acc1     <= {ACC_W{1'h0}};
         detect   <= 2'h0;
         average0 <= {DATA_W{1'h0}};
         average1 <= {DATA_W{1'h0}};
      end else begin
         acc0     <= next_acc0;
         acc1     <= next_acc1;
         detect   <= next_detect;
         average0 <= intPart(acc0);
         average1 <= intPart(acc1);
      end
   end

endmodule // adaptive_threshold_comparator

/* File: testbench/adaptive_threshold_comparator_asserts.sv */
`timescale 1ns/1ps
module adaptive_threshold_comparator_asserts #(parameter DATA_W = 16) (
   input wire              clk_sys,
   input wire              resetn,
   input wire [7:0]        regPointer,
   input wire              regWrite,
   input wire [7:0]        regWriteData,
   input wire [7:0]        regReadData,
   input wire              convStart,
   input wire              convChannel,
   input wire              convDone,
   input wire              powerDown,
   input wire [1:0]        detect,
   input wire [DATA_W-1:0] average0
);
   // alternation judged only while both channels run continuously
   wire cfgOk = regPointer == 8'h0f;
   wire both  = cfgOk && regReadData[4:0] == 5'h19;
   reg  lastCh;
   reg  seen;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lastCh <= 1'b0;
         seen   <= 1'b0;
      end else begin
         if (convStart) lastCh <= convChannel;
         seen <= both && (seen || convStart);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   reset_cfg_a: assert property (
      $rose(resetn) && cfgOk |-> regReadData == 8'h19) else $error("bad reset");
   cfg_write_a: assert property (
      regWrite && cfgOk && regWriteData[2:0] != 3'h2 ##1 cfgOk
      |-> regReadData == $past(regWriteData)) else $error("write lost");
   unmapped_read_a: assert property (
      !cfgOk |-> regReadData == 8'h00) else $error("unmapped read");
   power_down_a: assert property (
      cfgOk |-> powerDown == (regReadData[2:0] == 3'h3)) else $error("pd");
   no_conv_a: assert property (
      (cfgOk && regReadData[2:1] != 2'h1 && regReadData[2:0] != 3'h1)[*2]
      |-> !convStart) else $error("start while stopped");
   start_pulse_a: assert property (
      convStart |=> !convStart [*2]) else $error("start too long");
   alt_channel_a: assert property (
      convStart && both && seen |-> convChannel != lastCh) else $error("alt");
   detect_cause_a: assert property (
      !$stable(detect) |-> $past(convDone)) else $error("detect moved");
   avg_cause_a: assert property (
      !$stable(average0) |-> $past(convDone, 2) && !$past(convChannel, 2))
      else $error("average moved");
   cover property (convStart && convChannel);
   cover property (detect == 2'h3);
   cover property (regWrite && !cfgOk);
endmodule // adaptive_threshold_comparator_asserts

/* File: testbench/conv_core_model.sv */
`timescale 1ns/1ps
module conv_core_model (
   input  wire        clk_sys,
   input  wire        resetn,
   input  wire        convStart,
   input  wire [15:0] dataIn,
   output reg         convDone,
   output reg  [15:0] convData
);
   reg [3:0] cnt;
   // data toggles outside the done cycle so stale values never match
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt      <= 4'h0;
         convDone <= 1'b0;
         convData <= 16'h0;
      end else begin
         cnt      <= convStart ? 4'h4 : cnt - {3'h0, cnt != 4'h0};
         convDone <= cnt == 4'h1;
         convData <= cnt == 4'h1 ? dataIn : ~convData;
      end
   end
endmodule // conv_core_model

/* File: testbench/adaptive_threshold_comparator_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module adaptive_threshold_comparator_tb;
   logic        clk_sys, resetn, regWrite, convStart, convChannel, convDone;
   logic        powerDown, hystOff;
   logic [15:0] hystAmt;
   logic [7:0]  regPointer, regWriteData, regReadData;
   logic [3:0]  setCode;
   logic [15:0] dIn, convData, avg0, avg1, sens, thr0, thr1;
   logic [1:0]  detect;
   logic signed [39:0] acc [2] = '{40'sh0, 40'sh0};
   int error_cnt = 0, num_checks = 0, cycles = 0, nStart = 0;
   adaptive_threshold_comparator uut (.clk_sys(clk_sys), .resetn(resetn),
      .regPointer(regPointer), .regWrite(regWrite),
      .regWriteData(regWriteData), .regReadData(regReadData),
      .average_settling_code(setCode), .hysteresisDisable(hystOff),
      .hysteresisAmount(hystAmt), .sensitivity0(sens), .sensitivity1(sens),
      .fixedThreshold0(thr0), .fixedThreshold1(thr1), .convStart(convStart),
      .convChannel(convChannel), .convDone(convDone), .convData(convData),
      .powerDown(powerDown), .detect(detect), .average0(avg0),
      .average1(avg1));
   conv_core_model core (.clk_sys(clk_sys), .resetn(resetn),
      .convStart(convStart), .dataIn(dIn), .convDone(convDone),
      .convData(convData));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (convStart) nStart++;
      if (cycles == 3000) begin error_cnt++; finish_test(); end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic waitDone();
      do @(posedge clk_sys); while (convDone !== 1'b1);
   endtask
   function automatic logic det(input [7:0] c, input [15:0] d, a, s, t);
      logic [16:0] lo, hi;
      lo = c[7] ? t : (a < s ? 17'h0 : a - s); // lower limit clamps at 0
      hi = c[7] ? t : a + s;
      case (c[6:5])
         2'h0: det = d < lo;
         2'h1: det = d > hi;
         2'h2: det = !c[7] && d > lo && d < hi;
         default: det = d < lo || d > hi;
      endcase
   endfunction
   task automatic wr(input [7:0] p, input [7:0] v);
      regPointer <= p;
      regWrite <= 1'b1;
      regWriteData <= v;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regPointer <= 8'h0f;
   endtask
   task automatic t_regs();
      `CHK(regReadData, 8'h19)
      wr(8'h0e, 8'h00);
      @(posedge clk_sys);
      `CHK(regReadData, 8'h19)
      regPointer <= 8'h0e;
      @(posedge clk_sys);
      `CHK(regReadData, 8'h00)
      regPointer <= 8'h0f;
      $display("regs test done");
   endtask
   task automatic t_conv();
      logic [27:0] tab [17] = '{28'h1901000, 28'h1901000, 28'h1901000,
         28'h1901000, 28'h3911000, 28'h3910c00, 28'h1910a00, 28'h1911000,
         28'h5910c40, 28'h5910500, 28'h7910400, 28'h7910b00, 28'h9910700,
         28'hb910b00, 28'hd910800, 28'hf910a01, 28'h19fffff};
      logic [7:0] c;
      logic [3:0] sc;
      logic [15:0] d, m;
      logic ch, e;
      waitDone();
      for (int i = 0; i < 17; i++) begin
         {c, sc, d} = tab[i];
         wr(8'h0f, c);
         setCode <= sc;
         dIn <= d;
         hystOff <= (i < 8);
         waitDone();
         ch = convChannel;
         // hysteresis shrinks the margin of an output already active
         m = (!c[7] && i >= 8 && detect[ch]) ?
            (sens < hystAmt ? 16'h0 : sens - hystAmt) : sens;
         e = det(c, d, acc[ch][31:16], m, ch ? thr1 : thr0);
         acc[ch] = acc[ch] + (($signed({8'h0, d, 16'h0}) - acc[ch]) >>> (sc + 1));
         @(posedge clk_sys);
         `CHK(detect[ch], e)
         @(posedge clk_sys);
         `CHK(ch ? avg1 : avg0, acc[ch][31:16])
      end
      $display("conversion test done");
   endtask
   task automatic t_modes();
      logic [15:0] tab [4] = '{16'h1800, 16'h1b00, 16'h1a02, 16'h1c00};
      for (int i = 0; i < 4; i++) begin
         wr(8'h0f, tab[i][15:8]);
         nStart = 0;
         repeat (40) @(posedge clk_sys);
         `CHK(nStart[7:0], tab[i][7:0])
         `CHK(powerDown, tab[i][10:8] == 3'h3)
         `CHK(regReadData[2:0], tab[i][10:8] == 3'h2 ? 3'h0 : tab[i][10:8])
      end
      $display("mode test done");
   endtask
   initial begin
      {resetn, regWrite, regWriteData, setCode, dIn} = '0;
      {hystOff, hystAmt} = {1'b1, 16'h0080};
      {regPointer, sens, thr0, thr1} = {8'h0f, 16'h0100, 16'h0800, 16'h0a00};
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_conv();
      t_modes();
      finish_test();
   end
endmodule // adaptive_threshold_comparator_tb
bind adaptive_threshold_comparator adaptive_threshold_comparator_asserts #(
   .DATA_W(DATA_W)) chk (.clk_sys(clk_sys), .resetn(resetn),
   .regPointer(regPointer), .regWrite(regWrite), .regWriteData(regWriteData),
   .regReadData(regReadData), .convStart(convStart),
   .convChannel(convChannel), .convDone(convDone), .powerDown(powerDown),
   .detect(detect), .average0(average0));
